/* File: hw/cspre_clock_prescaler.sv */
// Clock source selection, base clock divider, 15-stage prescaler,
// prescaler tick requests and the stretched system reset.
// Assumes all pins are synchronous to i_clock; i_rst is the power-on reset.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps

// How it works
// - RC runs at ten selectable frequencies
// - Power-on uses RC; select bit picks external
// - Source switch happens only while both low
// - Oscillator disable accepted only with external active
// - Sleep stops the RC oscillator
// - Base clock is source divided by 1, 2, 4, 8 or 16
// - Ratio chosen to match source frequency
// - Fifteen binary stages from tap_15 to tap_1
// - Power-on loads prescaler with 0001
// - Clear resets tap_14..tap_2, sets tap_1
// - Fast tick on tap_4 or tap_7 rise
// - One-hertz tick on tap_1 rise
// - Debounce clock tap_8, tap_11 or tap_14
// - External select cleared by power-on only
// - No tick request caused by reset
// - First one-hertz tick 32768 base cycles later
// - System reset held twelve base cycles
module cspre_clock_prescaler
    import cspre_pkg::*;
(
    // System
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clock_en,
    // Register port
    input wire logic [CSPRE_ADDR_W-1:0] i_addr,
    input wire logic [CSPRE_DATA_W-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [CSPRE_DATA_W-1:0] o_rdata,
    // Pins and mode inputs
    input wire logic i_ext_clock_input_pin,
    input wire logic i_sleep,
    input wire logic i_sys_reset_request,
    // Clocks and ticks
    output logic o_processor_clock,
    output logic o_base_tick,
    output logic [15:1] o_prescaler_taps,
    output logic o_debounce_clock,
    output logic o_fast_tick_irq,
    output logic o_one_hertz_irq,
    output logic o_sys_reset,
    output logic o_rc_running
);

    logic ext_sel_reg;
    logic fast_sel_reg;
    logic deb_sel_reg;
    logic rc_off_reg;
    logic [2:0] div_ratio_reg;
    logic deb_long_reg;
    logic family_reg;
    logic [2:0] step_reg;
    logic [CSPRE_RC_CNT_W-1:0] rc_cnt_reg;
    logic rc_level_reg;
    logic rc_run_reg;
    logic proc_prev_reg;
    logic [3:0] div_cnt_reg;
    logic [15:1] taps_reg;
    logic fast_irq_reg;
    logic hz_irq_reg;
    logic sys_active_reg;
    logic [3:0] sys_cnt_reg;
    logic base_tick_reg;
    logic deb_clock_reg;
    logic [CSPRE_DATA_W-1:0] rdata_reg;
    logic proc_level;
    logic ext_active;

    // Register decode
    wire wr_presc = i_write && (i_addr == CSPRE_ADDR_PRESC);
    wire wr_sysctl2 = i_write && (i_addr == CSPRE_ADDR_SYSCTL2);
    wire wr_option = i_write && (i_addr == CSPRE_ADDR_OPTION);
    wire wr_rcfreq = i_write && (i_addr == CSPRE_ADDR_RCFREQ);
    wire clear_w = wr_presc && i_wdata[CSPRE_CLR_BIT];
    wire [2:0] wdata_low = i_wdata[2:0];
    wire [2:0] step_w = (wdata_low > CSPRE_STEP_MAX) ? CSPRE_STEP_MAX : wdata_low;
    wire [2:0] div_w = (wdata_low > CSPRE_DIV_MAX) ? CSPRE_DIV_MAX : wdata_low;

    wire [3:0] rd_presc = {ext_sel_reg, 1'b0, fast_sel_reg, deb_sel_reg};
    wire [3:0] rd_sysctl2 = {3'h0, rc_off_reg};
    wire [3:0] rd_option = {deb_long_reg, div_ratio_reg};
    wire [3:0] rd_rcfreq = {family_reg, step_reg};
    wire [3:0] rd_status = {sys_active_reg, rc_run_reg, ext_active, taps_reg[1]};
    wire [3:0] rd_mux =
        (i_addr == CSPRE_ADDR_PRESC) ? rd_presc :
        (i_addr == CSPRE_ADDR_SYSCTL2) ? rd_sysctl2 :
        (i_addr == CSPRE_ADDR_OPTION) ? rd_option :
        (i_addr == CSPRE_ADDR_RCFREQ) ? rd_rcfreq :
        (i_addr == CSPRE_ADDR_STATUS) ? rd_status : CSPRE_ZERO_NIB;

    // RC oscillator model
    wire [3:0] rc_index = 4'(step_reg) + (family_reg ? CSPRE_FAMILY_OFFSET : CSPRE_ZERO_NIB);
    wire [CSPRE_RC_CNT_W-1:0] rc_half = CSPRE_RC_HALF[rc_index];
    wire rc_run_w = !i_sleep && !(rc_off_reg && ext_active);
    wire rc_wrap = (rc_cnt_reg >= rc_half - 1'b1);

    // Source edge and base clock divider
    wire src_rise = proc_level && !proc_prev_reg;
    wire [3:0] div_mask = 4'((5'h01 << div_ratio_reg) - 5'h01);
    wire base_tick_w = src_rise && ((div_cnt_reg & div_mask) == div_mask);

    // Ripple carry through the prescaler stages
    wire [16:1] carry;
    wire [15:1] taps_next;
    wire [15:1] taps_rise;
    assign carry[16] = 1'b1;
    genvar k;
    generate
        for (k = 1; k <= CSPRE_TAPS; k = k + 1)
        begin : g_stage
            assign taps_next[k] = taps_reg[k] ^ carry[k+1];
            assign carry[k] = carry[k+1] & taps_reg[k];
            assign taps_rise[k] = carry[k+1] & !taps_reg[k];
        end
    endgenerate
    wire fast_rise = fast_sel_reg ? taps_rise[7] : taps_rise[4];
    wire deb_tap = deb_sel_reg ? (deb_long_reg ? taps_reg[14] : taps_reg[11]) : taps_reg[8];
    wire sys_done = base_tick_w && (sys_cnt_reg == CSPRE_RESET_HOLD - 1'b1);

    cspre_clock_switch u_switch (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clock_en(i_clock_en),
        .i_rc_level(rc_level_reg),
        .i_ext_level(i_ext_clock_input_pin),
        .i_select_ext(ext_sel_reg),
        .o_clock_level(proc_level),
        .o_ext_active(ext_active)
    );

    // Power-on-only settings
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            ext_sel_reg <= 1'b0;
            div_ratio_reg <= 3'h0;
            deb_long_reg <= 1'b0;
            family_reg <= 1'b0;
            step_reg <= 3'h0;
        end
        else if (i_clock_en)
        begin
            if (wr_presc)
                ext_sel_reg <= i_wdata[CSPRE_EXT_BIT];
            if (wr_option)
            begin
                div_ratio_reg <= div_w;
                deb_long_reg <= i_wdata[CSPRE_DEB_LONG_BIT];
            end
            if (wr_rcfreq)
            begin
                family_reg <= i_wdata[CSPRE_FAMILY_BIT];
                step_reg <= step_w;
            end
        end
    end

    // Settings cleared by any system reset
    always_ff @(posedge i_clock)
    begin
        if (i_rst || (i_clock_en && sys_active_reg))
        begin
            fast_sel_reg <= 1'b0;
            deb_sel_reg <= 1'b0;
            rc_off_reg <= 1'b0;
        end
        else if (i_clock_en)
        begin
            if (wr_presc)
            begin
                fast_sel_reg <= i_wdata[CSPRE_FAST_BIT];
                deb_sel_reg <= i_wdata[CSPRE_DEB_BIT];
            end
            if (wr_sysctl2 && (ext_active || !i_wdata[CSPRE_RCOFF_BIT]))
                rc_off_reg <= i_wdata[CSPRE_RCOFF_BIT];
        end
    end

    // RC oscillator and source divider
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            rc_cnt_reg <= '0;
            rc_level_reg <= 1'b0;
            rc_run_reg <= 1'b0;
            proc_prev_reg <= 1'b0;
            div_cnt_reg <= 4'h0;
            base_tick_reg <= 1'b0;
        end
        else if (i_clock_en)
        begin
            rc_run_reg <= rc_run_w;
            rc_cnt_reg <= (!rc_run_w || rc_wrap) ? '0 : rc_cnt_reg + 1'b1;
            rc_level_reg <= rc_run_w && (rc_level_reg ^ rc_wrap);
            proc_prev_reg <= proc_level;
            if (src_rise)
                div_cnt_reg <= div_cnt_reg + 4'h1;
            base_tick_reg <= base_tick_w;
        end
    end

    // Prescaler chain and tick requests
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            taps_reg <= CSPRE_PRESC_INIT;
            fast_irq_reg <= 1'b0;
            hz_irq_reg <= 1'b0;
            deb_clock_reg <= 1'b0;
        end
        else if (i_clock_en)
        begin
            deb_clock_reg <= deb_tap;
            if (clear_w)
                taps_reg <= (taps_reg & CSPRE_PRESC_KEEP) | CSPRE_PRESC_INIT;
            else if (base_tick_w)
                taps_reg <= taps_next;
            // Reset and clear never raise a request
            fast_irq_reg <= !clear_w && !sys_active_reg && base_tick_w && fast_rise;
            hz_irq_reg <= !clear_w && !sys_active_reg && base_tick_w && taps_rise[1];
        end
    end

    // System reset stretch, counted in base clock cycles
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            sys_active_reg <= 1'b1;
            sys_cnt_reg <= 4'h0;
        end
        else if (i_clock_en)
        begin
            if (i_sys_reset_request)
            begin
                sys_active_reg <= 1'b1;
                sys_cnt_reg <= 4'h0;
            end
            else if (sys_active_reg && base_tick_w)
            begin
                sys_active_reg <= !sys_done;
                sys_cnt_reg <= sys_done ? 4'h0 : sys_cnt_reg + 4'h1;
            end
        end
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
            rdata_reg <= '0;
        else if (i_clock_en)
            rdata_reg <= i_read ? rd_mux : CSPRE_ZERO_NIB;
    end

    assign o_rdata = rdata_reg;
    assign o_processor_clock = proc_level;
    assign o_base_tick = base_tick_reg;
    assign o_prescaler_taps = taps_reg;
    assign o_debounce_clock = deb_clock_reg;
    assign o_fast_tick_irq = fast_irq_reg;
    assign o_one_hertz_irq = hz_irq_reg;
    assign o_sys_reset = sys_active_reg;
    assign o_rc_running = rc_run_reg;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    property p_ext_after_por;
        $fell(i_rst) |-> !ext_sel_reg && !ext_active;
    endproperty
    a_ext_after_por: assert property (p_ext_after_por) else $error("external clock after power-on");

    property p_ext_kept;
        i_clock_en && sys_active_reg && !wr_presc |=> $stable(ext_sel_reg);
    endproperty
    a_ext_kept: assert property (p_ext_kept) else $error("system reset altered source select");

    property p_rc_off_needs_ext;
        rc_run_reg == 1'b0 && !$past(i_sleep) && !$past(i_rst) && $past(i_clock_en)
            |-> $past(rc_off_reg && ext_active);
    endproperty
    a_rc_off_needs_ext: assert property (p_rc_off_needs_ext) else $error("rc stopped without ext");

    property p_sleep_stops;
        i_clock_en && i_sleep |=> !rc_run_reg && !rc_level_reg;
    endproperty
    a_sleep_stops: assert property (p_sleep_stops) else $error("rc running in sleep");

    property p_clear;
        i_clock_en && clear_w |=> taps_reg[14:2] == 13'h0000 && taps_reg[1];
    endproperty
    a_clear: assert property (p_clear) else $error("prescaler clear wrong");

    property p_one_hz;
        i_clock_en && base_tick_w && taps_rise[1] && !clear_w && !sys_active_reg
            |=> o_one_hertz_irq && taps_reg[1];
    endproperty
    a_one_hz: assert property (p_one_hz) else $error("missed one-hertz tick");

    property p_fast_src;
        o_fast_tick_irq |-> ($past(fast_sel_reg) ? taps_reg[7] && !$past(taps_reg[7])
            : taps_reg[4] && !$past(taps_reg[4]));
    endproperty
    a_fast_src: assert property (p_fast_src) else $error("fast tick from wrong tap");

    property p_pulse;
        o_fast_tick_irq || o_one_hertz_irq |=> !o_fast_tick_irq && !o_one_hertz_irq;
    endproperty
    a_pulse: assert property (p_pulse) else $error("tick request longer than a cycle");

    property p_no_irq_reset;
        $past(sys_active_reg) |-> !o_fast_tick_irq && !o_one_hertz_irq;
    endproperty
    a_no_irq_reset: assert property (p_no_irq_reset) else $error("tick during reset");

    property p_reset_len;
        $fell(o_sys_reset) |-> $past(sys_cnt_reg) == CSPRE_RESET_HOLD - 1'b1 && $past(base_tick_w);
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("system reset length wrong");

    c_ext_switch: cover property (ext_active && $rose(proc_level));
    c_one_hz: cover property (o_one_hertz_irq);
    c_fast_slow: cover property (o_fast_tick_irq && fast_sel_reg);
    c_reset_end: cover property ($fell(o_sys_reset));

endmodule : cspre_clock_prescaler

/* File: hw/cspre_clock_switch.sv */
// Glitch-free selector between the RC oscillator and the external clock.
// Assumes both clock levels are already synchronous to i_clock.
`timescale 1ns/100ps
module cspre_clock_switch
    import cspre_pkg::*;
(
    // System
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clock_en,
    // Sources
    input wire logic i_rc_level,
    input wire logic i_ext_level,
    input wire logic i_select_ext,
    // Selected clock
    output logic o_clock_level,
    output logic o_ext_active
);

    logic sel_reg;
    logic out_reg;
    wire both_low = !i_rc_level && !i_ext_level;
    wire swap = (sel_reg != i_select_ext) && both_low;
    wire sel_next = swap ? i_select_ext : sel_reg;

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            sel_reg <= 1'b0;
            out_reg <= 1'b0;
        end
        else if (i_clock_en)
        begin
            sel_reg <= sel_next;
            out_reg <= sel_next ? i_ext_level : i_rc_level;
        end
    end

    assign o_clock_level = out_reg;
    assign o_ext_active = sel_reg;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // A source change happens only while both sources are low, so the output is low after it
    property p_switch_low;
        i_clock_en && swap |=> !out_reg;
    endproperty
    a_switch_low: assert property (p_switch_low) else $error("clock switched while high");

endmodule : cspre_clock_switch

/* File: hw/cspre_pkg.sv */
// Constants shared by the clock source and prescaler block.
// Assumes a single 100 MHz system clock drives all logic.
package cspre_pkg;

    // Bus geometry
    localparam int CSPRE_ADDR_W = 3;
    localparam int CSPRE_DATA_W = 4;

    // Register offsets
    localparam logic [2:0] CSPRE_ADDR_PRESC = 3'h0;
    localparam logic [2:0] CSPRE_ADDR_SYSCTL2 = 3'h1;
    localparam logic [2:0] CSPRE_ADDR_OPTION = 3'h2;
    localparam logic [2:0] CSPRE_ADDR_RCFREQ = 3'h3;
    localparam logic [2:0] CSPRE_ADDR_STATUS = 3'h4;

    // clock_prescaler_control fields
    localparam int CSPRE_EXT_BIT = 3;
    localparam int CSPRE_CLR_BIT = 2;
    localparam int CSPRE_FAST_BIT = 1;
    localparam int CSPRE_DEB_BIT = 0;
    // system_control_two fields
    localparam int CSPRE_RCOFF_BIT = 0;
    // option_register fields: divider ratio in [2:0], long debounce tap in [3]
    localparam int CSPRE_DEB_LONG_BIT = 3;
    // RC frequency register: step in [2:0], 50 kHz family in [3]
    localparam int CSPRE_FAMILY_BIT = 3;

    localparam logic [2:0] CSPRE_STEP_MAX = 3'h4;
    localparam logic [2:0] CSPRE_DIV_MAX = 3'h4;
    localparam logic [3:0] CSPRE_ZERO_NIB = 4'h0;

    // Prescaler chain
    localparam int CSPRE_TAPS = 15;
    localparam logic [15:1] CSPRE_PRESC_INIT = 15'h0001;
    localparam logic [15:1] CSPRE_PRESC_KEEP = 15'h4000;

    // System reset stretch in base clock cycles
    localparam logic [3:0] CSPRE_RESET_HOLD = 4'hc;

    // RC oscillator model: half periods in system clock cycles
    localparam int CSPRE_CLOCK_HZ = 100_000_000;
    localparam int CSPRE_RC_CNT_W = 11;
    localparam int CSPRE_RC_HZ [10] = '{
        32_000, 64_000, 128_000, 256_000, 500_000,
        50_000, 100_000, 200_000, 400_000, 800_000
    };
    localparam logic [10:0] CSPRE_RC_HALF [10] = '{
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[0])),
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[1])),
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[2])),
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[3])),
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[4])),
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[5])),
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[6])),
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[7])),
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[8])),
        11'(CSPRE_CLOCK_HZ / (2 * CSPRE_RC_HZ[9]))
    };
    localparam logic [3:0] CSPRE_FAMILY_OFFSET = 4'h5;

endpackage : cspre_pkg

/* File: tb/cspre_clock_prescaler_bench.sv */
// Self-checking bench for the clock source and prescaler block.
// Assumes a 100 MHz clock; the external clock model is scaled to short counts.
`timescale 1ns/100ps
module cspre_clock_prescaler_bench;
    import cspre_pkg::*;
    logic i_clock;
    logic i_rst = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [3:0] i_wdata = 4'h0;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic i_sleep = 1'b0;
    logic i_sys_reset_request = 1'b0;
    logic ext_run = 1'b0;
    logic [3:0] ext_half = 4'h4;
    logic ext_pin;
    logic [3:0] o_rdata;
    logic o_processor_clock, o_base_tick, o_debounce_clock, o_fast_tick_irq;
    logic o_one_hertz_irq, o_sys_reset, o_rc_running;
    logic [15:1] o_prescaler_taps;
    logic [15:1] tp_prev = 15'h0000;
    logic fi_prev = 1'b0;
    logic hz_prev = 1'b0;
    int num_errors = 0;
    int n_checks = 0;
    int deb_tap = 0;
    int hi = 0;
    bit gl = 0;
    int c, n, f, b, r;

    cspre_clock_prescaler dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_clock_en(1'b1),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
        .o_rdata(o_rdata), .i_ext_clock_input_pin(ext_pin), .i_sleep(i_sleep),
        .i_sys_reset_request(i_sys_reset_request),
        .o_processor_clock(o_processor_clock), .o_base_tick(o_base_tick),
        .o_prescaler_taps(o_prescaler_taps), .o_debounce_clock(o_debounce_clock),
        .o_fast_tick_irq(o_fast_tick_irq), .o_one_hertz_irq(o_one_hertz_irq),
        .o_sys_reset(o_sys_reset), .o_rc_running(o_rc_running)
    );

    cspre_ext_clock_model ext (
        .i_clock(i_clock), .i_run(ext_run), .i_half(ext_half), .o_pin(ext_pin)
    );

    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask : check_val

    task automatic final_report;
        $display("checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report

    // One cycle, landing just after the edge where outputs have settled
    task automatic step;
        @(posedge i_clock);
        #1;
    endtask : step

    task automatic wr_reg(input logic [2:0] a, input logic [3:0] d);
        // A strobe just dropped by the previous call: let one edge pass first
        if (i_write || i_read)
            step();
        i_write <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        step();
        i_write <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [2:0] a, input logic [3:0] exp);
        if (i_write || i_read)
            step();
        i_read <= 1'b1;
        i_addr <= a;
        step();
        i_read <= 1'b0;
        check_val(o_rdata, exp);
    endtask : rd_chk

    // Cycles up to the next base tick
    task automatic wait_tick(output int cyc);
        cyc = 0;
        do
        begin
            step();
            cyc++;
        end
        while (o_base_tick !== 1'b1 && cyc < 5000);
    endtask : wait_tick

    // Cycles up to the next rise of the processor clock
    task automatic edge_wait(output int cyc);
        logic p;
        cyc = 0;
        p = o_processor_clock;
        do
        begin
            p = o_processor_clock;
            step();
            cyc++;
        end
        while (!(o_processor_clock === 1'b1 && p === 1'b0) && cyc < 9000);
    endtask : edge_wait

    // Whole period of the processor clock, skipping one partial and one whole period
    task automatic period(output int cyc);
        edge_wait(cyc);
        edge_wait(cyc);
        edge_wait(cyc);
    endtask : period

    always @(posedge i_clock)
    begin
        #1;
        check_val(o_sys_reset & (o_fast_tick_irq | o_one_hertz_irq), 1'b0);
        check_val((o_fast_tick_irq & fi_prev) | (o_one_hertz_irq & hz_prev), 1'b0);
        if (o_processor_clock === 1'b1)
            hi++;
        else
        begin
            if (gl && hi > 0)
                check_val(hi < 4, 1'b0);
            hi = 0;
        end
        if (deb_tap > 0)
            check_val(o_debounce_clock !== o_prescaler_taps[deb_tap]
                && o_debounce_clock !== tp_prev[deb_tap], 1'b0);
        tp_prev = o_prescaler_taps;
        fi_prev = o_fast_tick_irq;
        hz_prev = o_one_hertz_irq;
    end

    initial
    begin
        repeat (120000) @(posedge i_clock);
        num_errors++;
        final_report();
    end

    initial
    begin
        repeat (16) step();
        check_val(o_prescaler_taps, 15'h0001);
        check_val(o_sys_reset, 1'b1);
        i_rst <= 1'b0;
        step();
        rd_chk(3'h0, 4'h0);
        rd_chk(3'h5, 4'h0);
        wr_reg(3'h7, 4'hf);
        for (r = 0; r < 10; r++)
        begin
            wr_reg(CSPRE_ADDR_RCFREQ, (r < 5) ? 4'(r) : 4'(r + 3));
            // First rise may close a partial period
            edge_wait(c);
            edge_wait(c);
            check_val((c > 2 * CSPRE_RC_HALF[r] - 3) && (c < 2 * CSPRE_RC_HALF[r] + 3), 1);
        end
        c = 0;
        while (o_sys_reset !== 1'b0 && c < 20000)
        begin
            step();
            c++;
        end
        check_val(o_sys_reset, 1'b0);
        // Disable is refused while the RC is the source; the selects are taken once the reset ends
        wr_reg(CSPRE_ADDR_SYSCTL2, 4'h1);
        rd_chk(CSPRE_ADDR_SYSCTL2, 4'h0);
        check_val(o_rc_running, 1'b1);
        wr_reg(CSPRE_ADDR_PRESC, 4'h7);
        rd_chk(CSPRE_ADDR_PRESC, 4'h3);
        wr_reg(CSPRE_ADDR_PRESC, 4'h0);
        ext_run <= 1'b1;
        gl = 1;
        wr_reg(CSPRE_ADDR_OPTION, 4'h0);
        wr_reg(CSPRE_ADDR_PRESC, 4'h8);
        period(c);
        check_val(c, 8);
        wr_reg(CSPRE_ADDR_PRESC, 4'h0);
        period(c);
        check_val(c, 2 * CSPRE_RC_HALF[9]);
        wr_reg(CSPRE_ADDR_PRESC, 4'h8);
        period(c);
        check_val(c, 8);
        for (int k = 0; k < 6; k++)
        begin
            n = (k == 5) ? 7 : k;
            wr_reg(CSPRE_ADDR_OPTION, 4'(n));
            wait_tick(c);
            wait_tick(c);
            wait_tick(c);
            check_val(c, 8 << ((k == 5) ? 4 : k));
        end
        period(c);
        check_val(c, 8);
        i_sleep <= 1'b1;
        repeat (4) step();
        check_val(o_rc_running, 1'b0);
        i_sleep <= 1'b0;
        repeat (4) step();
        check_val(o_rc_running, 1'b1);
        wr_reg(CSPRE_ADDR_SYSCTL2, 4'h1);
        repeat (4) step();
        check_val(o_rc_running, 1'b0);
        rd_chk(CSPRE_ADDR_SYSCTL2, 4'h1);
        gl = 0;
        ext_half <= 4'h1;
        wr_reg(CSPRE_ADDR_OPTION, 4'h0);
        repeat (4) step();
        deb_tap = 8;
        wr_reg(CSPRE_ADDR_PRESC, 4'hc);
        check_val(o_prescaler_taps[14:1], 14'h0001);
        check_val(o_one_hertz_irq, 1'b0);
        b = o_prescaler_taps[15];
        n = 0;
        f = 0;
        while (o_one_hertz_irq !== 1'b1 && n < 40000)
        begin
            step();
            n += o_base_tick === 1'b1;
            f += o_fast_tick_irq === 1'b1;
        end
        check_val(n, 32768 - b);
        check_val(f, 8);
        check_val(o_prescaler_taps[1], 1'b1);
        rd_chk(CSPRE_ADDR_PRESC, 4'h8);
        wr_reg(CSPRE_ADDR_PRESC, 4'ha);
        c = 0;
        while (o_fast_tick_irq !== 1'b1 && c < 3000)
        begin
            step();
            c++;
        end
        n = 0;
        do
        begin
            step();
            n += o_base_tick === 1'b1;
        end
        while (o_fast_tick_irq !== 1'b1 && n < 3000);
        check_val(n, 512);
        deb_tap = 0;
        wr_reg(CSPRE_ADDR_PRESC, 4'h9);
        repeat (2) step();
        deb_tap = 11;
        repeat (300) step();
        deb_tap = 0;
        wr_reg(CSPRE_ADDR_OPTION, 4'h8);
        repeat (2) step();
        deb_tap = 14;
        repeat (100) step();
        deb_tap = 0;
        i_sys_reset_request <= 1'b1;
        step();
        i_sys_reset_request <= 1'b0;
        c = 0;
        while (o_sys_reset !== 1'b1 && c < 4)
        begin
            step();
            c++;
        end
        // A tick on the request edge restarts the count, so it is skipped
        n = 0;
        do
        begin
            step();
            c++;
            n += o_base_tick === 1'b1;
        end
        while (o_sys_reset === 1'b1 && c < 2000);
        check_val(n, 12);
        rd_chk(CSPRE_ADDR_PRESC, 4'h8);
        rd_chk(CSPRE_ADDR_SYSCTL2, 4'h0);
        repeat (4) step();
        check_val(o_rc_running, 1'b1);
        i_rst <= 1'b1;
        repeat (2) step();
        check_val(o_prescaler_taps, 15'h0001);
        i_rst <= 1'b0;
        step();
        rd_chk(CSPRE_ADDR_PRESC, 4'h0);
        final_report();
    end
endmodule : cspre_clock_prescaler_bench

/* File: tb/cspre_ext_clock_model.sv */
// External square-wave clock source feeding the clock input pin.
// Assumes the bench clock; the level changes only just after rising edges.
`timescale 1ns/100ps
module cspre_ext_clock_model
(
    // Control
    input wire logic i_clock,
    input wire logic i_run,
    input wire logic [3:0] i_half,
    // Pin
    output logic o_pin
);
    logic [3:0] cnt_reg = 4'h0;

    // Runs only while told to; parked low when stopped
    always @(posedge i_clock)
    begin
        if (!i_run)
        begin
            o_pin <= 1'b0;
            cnt_reg <= 4'h0;
        end
        else if (cnt_reg + 4'h1 >= i_half)
        begin
            o_pin <= ~o_pin;
            cnt_reg <= 4'h0;
        end
        else
            cnt_reg <= cnt_reg + 4'h1;
    end
endmodule : cspre_ext_clock_model
